/* File: rtl/fir_instruction_field_decoder.sv */
// fir instruction field decoder with apb register access and result routing
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fir_instruction_field_decoder
  import fir_instr_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // compute engine events
  input  wire logic                tap_i,
  input  wire logic                run_done_i,
  input  wire logic                data_in_valid_i,
  input  wire logic [DATA_W-1:0]   data_in_i_i,
  input  wire logic [DATA_W-1:0]   data_in_q_i,
  input  wire logic                result_valid_i,
  input  wire logic [DATA_W-1:0]   result_i_i,
  input  wire logic [DATA_W-1:0]   result_q_i,
  // polar converter return
  input  wire logic                polar_valid_i,
  input  wire logic [DATA_W-1:0]   polar_mag_i,
  input  wire logic [DATA_W-1:0]   polar_dphi_i,
  // decoded instruction
  output fir_kind_e                fir_kind_o,
  output logic                     run_active_o,
  output logic [DATA_W-1:0]        round_add_o,
  output logic [DADDR_W-1:0]       data_addr_o,
  // rotated engine input
  output logic                     rot_valid_o,
  output logic [DATA_W-1:0]        rot_i_o,
  output logic [DATA_W-1:0]        rot_q_o,
  // recirculation to the engine
  output logic                     recirc_valid_o,
  output logic [DATA_W-1:0]        recirc_i_o,
  output logic [DATA_W-1:0]        recirc_q_o,
  output logic [STEP_W-1:0]        recirc_step_o,
  // fifo and agc path
  output logic                     agc_fwd_valid_o,
  output logic [DATA_W-1:0]        agc_path_i_out_o,
  output logic [DATA_W-1:0]        agc_path_q_out_o,
  output logic                     agc_loop_update_o,
  output logic                     agc_loop_gain_sel_o,
  // direct path and next channel
  output logic                     direct_valid_o,
  output logic [DATA_W-1:0]        direct_path_i_out_o,
  output logic [DATA_W-1:0]        direct_path_q_out_o,
  output logic                     next_chan_valid_o,
  // output section
  output logic [DATA_W-1:0]        hold_i_o,
  output logic [DATA_W-1:0]        hold_q_o,
  output logic                     data_ready_o,
  output logic                     serial_start_o
);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [31:0]          instr_lo_reg;
  logic [HI_USED_W-1:0] instr_hi_reg;
  logic [63:0]          instr_word;
  logic                 setup_phase;
  logic                 access_done;
  logic                 wr_en;
  logic                 hit_lo;
  logic                 hit_hi;
  logic                 hit_ctrl;
  logic                 hit_stat;
  logic                 addr_ok;
  logic [31:0]          rd_mux;
  logic [31:0]          status_word;
  logic                 start_pulse;

  assign setup_phase = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_o;
  assign hit_lo      = (paddr_i == OFS_INSTR_LO);
  assign hit_hi      = (paddr_i == OFS_INSTR_HI);
  assign hit_ctrl    = (paddr_i == OFS_CTRL);
  assign hit_stat    = (paddr_i == OFS_STATUS);
  assign addr_ok     = hit_lo | hit_hi | hit_ctrl | hit_stat;
  assign wr_en       = access_done & pwrite_i & addr_ok;
  assign start_pulse = wr_en & hit_ctrl & pwdata_i[CTRL_START];
  assign instr_word  = {{(32-HI_USED_W){1'b0}}, instr_hi_reg, instr_lo_reg};

  assign rd_mux = hit_lo   ? instr_lo_reg :
                  hit_hi   ? {{(32-HI_USED_W){1'b0}}, instr_hi_reg} :
                  hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o     <= 1'b0;
      pslverr_o    <= 1'b0;
      prdata_o     <= 32'h0000_0000;
      instr_lo_reg <= 32'h0000_0000;
      instr_hi_reg <= '0;
    end else begin
      // no wait states: answer decided during setup
      pready_o  <= setup_phase;
      pslverr_o <= setup_phase & ~addr_ok;
      prdata_o  <= setup_phase & ~pwrite_i ? rd_mux : 32'h0000_0000;
      if (wr_en & hit_lo) begin
        instr_lo_reg <= pwdata_i;
      end
      if (wr_en & hit_hi) begin
        instr_hi_reg <= pwdata_i[HI_USED_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [TYPE_W-1:0]  type_code;
  fir_kind_e          kind_dec;
  logic               kind_runs;
  logic [ROUND_W-1:0] round_code;
  logic [DATA_W-1:0]  round_dec;

  assign type_code  = instr_word[TYPE_LSB +: TYPE_W];
  assign round_code = instr_word[ROUND_LSB +: ROUND_W];

  always_comb begin
    unique case (type_code)
      TYPE_NOP:     kind_dec = KIND_NOP;
      TYPE_SYM_EE:  kind_dec = KIND_SYM_EE;
      TYPE_SYM_EO:  kind_dec = KIND_SYM_EO;
      TYPE_SYM_OE:  kind_dec = KIND_SYM_OE;
      TYPE_SYM_OO:  kind_dec = KIND_SYM_OO;
      TYPE_ASYM:    kind_dec = KIND_ASYM;
      TYPE_RESAMP:  kind_dec = KIND_RESAMP;
      TYPE_INTERP:  kind_dec = KIND_INTERP_HB;
      TYPE_COMPLEX: kind_dec = KIND_COMPLEX;
      default:      kind_dec = KIND_RESERVED;
    endcase
  end

  // reserved codes behave as a no-op so they cannot drive the engine
  assign kind_runs = (kind_dec != KIND_NOP) & (kind_dec != KIND_RESERVED);

  // bit 0 of the rounding field is 2^-24
  assign round_dec = (round_code == ROUND_NONE) ? '0
                                                : DATA_W'(1) << round_code;

  // ---------------------------------------------------------------
  // latched instruction for the current run
  // ---------------------------------------------------------------
  logic              rot_en_reg;
  logic [1:0]        route_reg;
  logic              os_reg;
  logic              fb_reg;
  logic              upd_reg;
  logic [1:0]        rot_phase_reg;
  logic              reserved_seen_reg;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fir_kind_o          <= KIND_NOP;
      run_active_o        <= 1'b0;
      round_add_o         <= '0;
      rot_en_reg          <= 1'b0;
      route_reg           <= ROUTE_RECIRC;
      os_reg              <= 1'b0;
      fb_reg              <= 1'b0;
      upd_reg             <= 1'b0;
      agc_loop_gain_sel_o <= 1'b0;
      recirc_step_o       <= '0;
      reserved_seen_reg   <= 1'b0;
    end else if (start_pulse) begin
      fir_kind_o          <= kind_dec;
      run_active_o        <= kind_runs;
      round_add_o         <= round_dec;
      rot_en_reg          <= instr_word[ROT_BIT];
      route_reg           <= instr_word[ROUTE_LSB +: 2];
      os_reg              <= instr_word[OS_BIT];
      fb_reg              <= instr_word[FB_BIT];
      upd_reg             <= instr_word[UPD_BIT];
      agc_loop_gain_sel_o <= instr_word[GAIN_BIT];
      recirc_step_o       <= instr_word[STEP_LSB +: STEP_W];
      reserved_seen_reg   <= (kind_dec == KIND_RESERVED);
    end else if (run_done_i) begin
      run_active_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // data block addressing
  // ---------------------------------------------------------------
  // base above 383 is not trapped; software keeps it in range
  data_block_addr u_data_block_addr (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .load_i      (start_pulse & kind_runs),
    .base_i      (instr_word[DBASE_LSB +: DADDR_W]),
    .size_code_i (instr_word[DSIZE_LSB +: DSIZE_W]),
    .step_i      (instr_word[DSTEP_LSB +: DSTEP_W]),
    .tap_i       (tap_i & run_active_o),
    .run_done_i  (run_done_i & run_active_o),
    .addr_o      (data_addr_o)
  );

  // ---------------------------------------------------------------
  // rotating mixer on engine input
  // ---------------------------------------------------------------
  logic              rot_step;
  logic [DATA_W-1:0] neg_i;
  logic [DATA_W-1:0] neg_q;
  logic [DATA_W-1:0] rot_i_next;
  logic [DATA_W-1:0] rot_q_next;

  assign rot_step = data_in_valid_i & run_active_o;
  assign neg_i    = DATA_W'(-data_in_i_i);
  assign neg_q    = DATA_W'(-data_in_q_i);

  // phases 0..3 multiply by 1, j, -1, -j
  always_comb begin
    rot_i_next = data_in_i_i;
    rot_q_next = data_in_q_i;
    if (rot_en_reg) begin
      unique case (rot_phase_reg)
        2'h0: begin
          rot_i_next = data_in_i_i;
          rot_q_next = data_in_q_i;
        end
        2'h1: begin
          rot_i_next = neg_q;
          rot_q_next = data_in_i_i;
        end
        2'h2: begin
          rot_i_next = neg_i;
          rot_q_next = neg_q;
        end
        2'h3: begin
          rot_i_next = data_in_q_i;
          rot_q_next = neg_i;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rot_phase_reg <= 2'h0;
      rot_valid_o   <= 1'b0;
      rot_i_o       <= '0;
      rot_q_o       <= '0;
    end else begin
      rot_valid_o <= rot_step;
      if (start_pulse) begin
        rot_phase_reg <= 2'h0;
      end else if (rot_step) begin
        rot_phase_reg <= 2'(rot_phase_reg + 2'h1);
      end
      if (rot_step) begin
        rot_i_o <= rot_i_next;
        rot_q_o <= rot_q_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // result routing
  // ---------------------------------------------------------------
  logic res_take;
  logic to_recirc;
  logic to_agc;
  logic to_direct;
  logic to_output;
  logic fb_take;

  assign res_take  = result_valid_i & run_active_o;
  assign to_recirc = res_take & (route_reg == ROUTE_RECIRC);
  assign to_agc    = res_take & (route_reg == ROUTE_AGC);
  assign to_direct = res_take & (route_reg == ROUTE_DIRECT);
  assign to_output = to_agc | to_direct;
  // engine result has the recirculation slot when both arrive together
  assign fb_take   = polar_valid_i & fb_reg & ~to_recirc;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      recirc_valid_o      <= 1'b0;
      recirc_i_o          <= '0;
      recirc_q_o          <= '0;
      agc_fwd_valid_o     <= 1'b0;
      agc_path_i_out_o    <= '0;
      agc_path_q_out_o    <= '0;
      agc_loop_update_o   <= 1'b0;
      direct_valid_o      <= 1'b0;
      direct_path_i_out_o <= '0;
      direct_path_q_out_o <= '0;
      next_chan_valid_o   <= 1'b0;
      hold_i_o            <= '0;
      hold_q_o            <= '0;
      data_ready_o        <= 1'b0;
      serial_start_o      <= 1'b0;
    end else begin
      recirc_valid_o    <= to_recirc | fb_take;
      agc_fwd_valid_o   <= to_agc;
      agc_loop_update_o <= to_agc & upd_reg;
      direct_valid_o    <= to_direct;
      next_chan_valid_o <= to_direct;
      data_ready_o      <= to_output & os_reg;
      serial_start_o    <= to_output & os_reg;
      if (to_recirc) begin
        recirc_i_o <= result_i_i;
        recirc_q_o <= result_q_i;
      end else if (fb_take) begin
        recirc_i_o <= polar_mag_i;
        recirc_q_o <= polar_dphi_i;
      end
      if (to_agc) begin
        agc_path_i_out_o <= result_i_i;
        agc_path_q_out_o <= result_q_i;
      end
      if (to_direct) begin
        direct_path_i_out_o <= result_i_i;
        direct_path_q_out_o <= result_q_i;
      end
      // holding register loads whether or not the strobe is set
      if (to_output) begin
        hold_i_o <= result_i_i;
        hold_q_o <= result_q_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // status readback
  // ---------------------------------------------------------------
  assign status_word = {10'h000, data_addr_o, 4'(fir_kind_o),
                        3'h0, os_reg, route_reg, reserved_seen_reg, run_active_o};

endmodule // fir_instruction_field_decoder
`default_nettype wire

/* File: rtl/fir_instr_pkg.sv */
// constants, field layout and types for the fir instruction field decoder
package fir_instr_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFS_INSTR_LO = 12'h000;
  localparam logic [11:0] OFS_INSTR_HI = 12'h004;
  localparam logic [11:0] OFS_CTRL     = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00c;
  localparam int          CTRL_START   = 0;
  localparam int          HI_USED_W    = 21;

  // ---------------------------------------------------------------
  // instruction fields, positions in the 64-bit word
  // ---------------------------------------------------------------
  localparam int ROT_BIT    = 0;
  localparam int TYPE_LSB   = 9;
  localparam int TYPE_W     = 6;
  localparam int STEP_LSB   = 18;
  localparam int STEP_W     = 5;
  localparam int FB_BIT     = 23;
  localparam int OS_BIT     = 24;
  localparam int ROUTE_LSB  = 25;
  localparam int UPD_BIT    = 27;
  localparam int GAIN_BIT   = 28;
  localparam int ROUND_LSB  = 29;
  localparam int ROUND_W    = 3;
  localparam int DBASE_LSB  = 32;
  localparam int DADDR_W    = 10;
  localparam int DSIZE_LSB  = 42;
  localparam int DSIZE_W    = 3;
  localparam int DSTEP_LSB  = 45;
  localparam int DSTEP_W    = 8;
  localparam int DATA_W     = 24;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [5:0] TYPE_NOP      = 6'h00;
  localparam logic [5:0] TYPE_SYM_EE   = 6'h01;
  localparam logic [5:0] TYPE_SYM_EO   = 6'h02;
  localparam logic [5:0] TYPE_SYM_OE   = 6'h03;
  localparam logic [5:0] TYPE_SYM_OO   = 6'h04;
  localparam logic [5:0] TYPE_ASYM     = 6'h05;
  localparam logic [5:0] TYPE_RESAMP   = 6'h08;
  localparam logic [5:0] TYPE_INTERP   = 6'h09;
  localparam logic [5:0] TYPE_COMPLEX  = 6'h20;
  localparam logic [1:0] ROUTE_RECIRC  = 2'h0;
  localparam logic [1:0] ROUTE_AGC     = 2'h1;
  localparam logic [1:0] ROUTE_DIRECT  = 2'h2;
  localparam logic [2:0] ROUND_NONE    = 3'h7;
  localparam logic [9:0] MIN_BLOCK     = 10'h007;

  typedef enum logic [3:0] {
    KIND_NOP, KIND_SYM_EE, KIND_SYM_EO, KIND_SYM_OE, KIND_SYM_OO,
    KIND_ASYM, KIND_RESAMP, KIND_INTERP_HB, KIND_COMPLEX, KIND_RESERVED
  } fir_kind_e;

endpackage

/* File: rtl/data_block_addr.sv */
// data memory block address generator with modulo wrap and block stepping
`timescale 1ns/1ps
`default_nettype none
module data_block_addr
  import fir_instr_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // block setup, taken on load
  input  wire logic               load_i,
  input  wire logic [DADDR_W-1:0] base_i,
  input  wire logic [DSIZE_W-1:0] size_code_i,
  input  wire logic [DSTEP_W-1:0] step_i,
  // engine events
  input  wire logic               tap_i,
  input  wire logic               run_done_i,
  // address
  output logic      [DADDR_W-1:0] addr_o
);

  logic [DADDR_W-1:0] base_reg;
  logic [DADDR_W-1:0] mask_reg;
  logic [DSTEP_W-1:0] step_reg;
  logic [DADDR_W-1:0] ptr_reg;
  logic [DADDR_W-1:0] ptr_next;
  logic [DADDR_W-1:0] mask_next;
  logic [DADDR_W-1:0] addr_next;

  // 8 words for code 0, doubling to 1024 for code 7
  assign mask_next = ~DADDR_W'(~MIN_BLOCK << size_code_i);

  // a step of zero leaves the block in place for interpolation runs
  assign ptr_next  = load_i     ? '0 :
                     run_done_i ? DADDR_W'(ptr_reg + DADDR_W'(step_reg)) :
                     tap_i      ? DADDR_W'(ptr_reg - DADDR_W'(1)) : ptr_reg;

  // wrap inside the block, then offset by the base
  assign addr_next = load_i ? base_i
                            : DADDR_W'(base_reg + (ptr_next & mask_reg));

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      base_reg <= '0;
      mask_reg <= MIN_BLOCK;
      step_reg <= '0;
      ptr_reg  <= '0;
      addr_o   <= '0;
    end else begin
      if (load_i) begin
        base_reg <= base_i;
        mask_reg <= mask_next;
        step_reg <= step_i;
      end
      ptr_reg <= ptr_next;
      addr_o  <= addr_next;
    end
  end

endmodule // data_block_addr
`default_nettype wire

/* File: testbench/fir_decoder_asserts.sv */
// checker of decode and routing relations at the decoder ports
`timescale 1ns/1ps
`default_nettype none
module fir_decoder_asserts
  import fir_instr_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  // engine events
  input wire logic              result_valid_i,
  input wire logic [DATA_W-1:0] result_i_i,
  input wire logic              polar_valid_i,
  input wire logic              data_in_valid_i,
  // decoded and routed outputs
  input wire fir_kind_e         fir_kind_o,
  input wire logic              run_active_o,
  input wire logic [DATA_W-1:0] round_add_o,
  input wire logic              rot_valid_o,
  input wire logic              recirc_valid_o,
  input wire logic              agc_fwd_valid_o,
  input wire logic [DATA_W-1:0] agc_path_i_out_o,
  input wire logic              agc_loop_update_o,
  input wire logic              direct_valid_o,
  input wire logic              next_chan_valid_o,
  input wire logic [DATA_W-1:0] direct_path_i_out_o,
  input wire logic [DATA_W-1:0] hold_i_o,
  input wire logic              data_ready_o,
  input wire logic              serial_start_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_RUN_KIND: assert property (
    run_active_o |-> !(fir_kind_o inside {KIND_NOP, KIND_RESERVED}))
    else $error("run active on nop or reserved type");
  AST_ROUND: assert property (
    $onehot0(round_add_o) && round_add_o[DATA_W-1:7] == '0)
    else $error("rounding weight out of range");
  AST_RECIRC_SRC: assert property (
    recirc_valid_o |-> $past(result_valid_i) || $past(polar_valid_i))
    else $error("recirculation without a source");
  AST_AGC_FWD: assert property (
    agc_fwd_valid_o |-> $past(result_valid_i) && agc_path_i_out_o == $past(result_i_i))
    else $error("agc path output not from result");
  AST_AGC_UPD: assert property (
    agc_loop_update_o |-> agc_fwd_valid_o)
    else $error("loop update off the agc path");
  AST_DIRECT: assert property (
    direct_valid_o |-> next_chan_valid_o && direct_path_i_out_o == $past(result_i_i))
    else $error("direct output mismatch");
  AST_STROBE: assert property (
    data_ready_o |-> serial_start_o && (agc_fwd_valid_o || direct_valid_o))
    else $error("data ready without output");
  AST_HOLD: assert property (
    agc_fwd_valid_o || direct_valid_o |-> hold_i_o == $past(result_i_i))
    else $error("holding register not loaded");
  AST_ROT: assert property (
    rot_valid_o |-> $past(data_in_valid_i) && $past(run_active_o))
    else $error("rotated sample without input");
endmodule // fir_decoder_asserts

bind fir_instruction_field_decoder fir_decoder_asserts u_chk (.clk_sys_i, .reset_i, .result_valid_i,
  .result_i_i, .polar_valid_i, .data_in_valid_i, .fir_kind_o, .run_active_o, .round_add_o, .rot_valid_o,
  .recirc_valid_o, .agc_fwd_valid_o, .agc_path_i_out_o, .agc_loop_update_o, .direct_valid_o,
  .next_chan_valid_o, .direct_path_i_out_o, .hold_i_o, .data_ready_o, .serial_start_o);
`default_nettype wire

/* File: testbench/fir_cpu_model.sv */
// apb master model of the processor that loads instruction words
`timescale 1ns/1ps
`default_nettype none
module fir_cpu_model
  import fir_instr_pkg::*;
(
  // clock
  input  wire logic              clk_sys_i,
  // apb master
  output logic                   psel_o,
  output logic                   penable_o,
  output logic                   pwrite_o,
  output logic      [ADDR_W-1:0] paddr_o,
  output logic      [31:0]       pwdata_o,
  input  wire logic [31:0]       prdata_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i
);
  initial begin
    {psel_o, penable_o, pwrite_o} = 3'h0;
    paddr_o = '0;
    pwdata_o = '0;
  end
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_sys_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    do @(posedge clk_sys_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    er = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released lines flip so stale values cannot pass for good ones
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
  task automatic load(input logic [52:0] w);
    logic [31:0] rd;
    logic        er;
    w[GAIN_BIT] = 1'b0;
    if (w[DBASE_LSB+:DADDR_W] > 10'd383) w[DBASE_LSB+:DADDR_W] = '0;
    xfer(1'b1, OFS_INSTR_LO, w[31:0], rd, er);
    xfer(1'b1, OFS_INSTR_HI, {11'h0, w[52:32]}, rd, er);
    xfer(1'b1, OFS_CTRL, 32'h1, rd, er);
  endtask
endmodule // fir_cpu_model
`default_nettype wire

/* File: testbench/fir_instruction_field_decoder_tb.sv */
// self-checking bench for the fir instruction field decoder
`timescale 1ns/1ps
`default_nettype none
module fir_instruction_field_decoder_tb;
  import fir_instr_pkg::*;
  logic               clk_sys_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [ADDR_W-1:0]  paddr_i;
  logic [31:0]        pwdata_i, prdata_o;
  logic               tap_i, run_done_i, data_in_valid_i, result_valid_i, polar_valid_i;
  logic [DATA_W-1:0]  data_in_i_i, data_in_q_i, result_i_i, result_q_i, polar_mag_i, polar_dphi_i;
  fir_kind_e          fir_kind_o;
  logic               run_active_o, rot_valid_o, recirc_valid_o, agc_fwd_valid_o, agc_loop_update_o;
  logic               agc_loop_gain_sel_o, direct_valid_o, next_chan_valid_o, data_ready_o, serial_start_o;
  logic [DATA_W-1:0]  round_add_o, rot_i_o, rot_q_o, recirc_i_o, recirc_q_o, agc_path_i_out_o;
  logic [DATA_W-1:0]  direct_path_i_out_o, hold_i_o;
  logic [DADDR_W-1:0] data_addr_o;
  logic [STEP_W-1:0]  recirc_step_o;
  int                 err_total = 0, compares = 0, cyc = 0;

  fir_instruction_field_decoder u_dut (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tap_i, .run_done_i, .data_in_valid_i, .data_in_i_i,
    .data_in_q_i, .result_valid_i, .result_i_i, .result_q_i, .polar_valid_i, .polar_mag_i, .polar_dphi_i,
    .fir_kind_o, .run_active_o, .round_add_o, .data_addr_o, .rot_valid_o, .rot_i_o, .rot_q_o,
    .recirc_valid_o, .recirc_i_o, .recirc_q_o, .recirc_step_o, .agc_fwd_valid_o, .agc_path_i_out_o,
    .agc_path_q_out_o(), .agc_loop_update_o, .agc_loop_gain_sel_o, .direct_valid_o, .direct_path_i_out_o,
    .direct_path_q_out_o(), .next_chan_valid_o, .hold_i_o, .hold_q_o(), .data_ready_o, .serial_start_o);
  fir_cpu_model u_cpu (.clk_sys_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
    .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // k: 0 result, 1 polar, 2 data in, 3 tap, 4 run done
  task automatic pulse(input int k, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    @(posedge clk_sys_i);
    {result_valid_i, polar_valid_i, data_in_valid_i, tap_i, run_done_i} <= 5'h10 >> k;
    {result_i_i, polar_mag_i, data_in_i_i} <= {3{a}};
    {result_q_i, polar_dphi_i, data_in_q_i} <= {3{b}};
    @(posedge clk_sys_i);
    {result_valid_i, polar_valid_i, data_in_valid_i, tap_i, run_done_i} <= 5'h0;
    {result_i_i, polar_mag_i, data_in_i_i} <= {3{~a}};
    #1;
  endtask
  function automatic logic [52:0] mk(input logic [5:0] ty, input logic [10:0] dst, input logic [2:0] rnd,
                                     input logic [9:0] base, input logic [2:0] sz, input logic rot);
    return {8'h03, sz, base, rnd, dst, 3'h0, ty, 8'h00, rot};
  endfunction
  task automatic start(input logic [52:0] w);
    u_cpu.load(w);
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic t_types();
    logic [5:0] codes [10];
    codes = '{TYPE_NOP, TYPE_SYM_EE, TYPE_SYM_EO, TYPE_SYM_OE, TYPE_SYM_OO, TYPE_ASYM, TYPE_RESAMP,
              TYPE_INTERP, TYPE_COMPLEX, 6'h3f};
    for (int n = 0; n < 10; n++) begin
      start(mk(codes[n], 11'h040, 3'h0, 10'h0, 3'h7, 1'b0));
      chk("fir_kind_o", n, fir_kind_o);
      chk("run_active_o", n != 0 && n != 9, run_active_o);
      pulse(4, '0, '0);
    end
    for (int c = 0; c < 8; c++) begin
      start(mk(TYPE_ASYM, 11'h0, c[2:0], 10'h0, 3'h7, 1'b0));
      chk("round_add_o", c == 7 ? 0 : 1 << c, round_add_o);
      pulse(4, '0, '0);
    end
    $display("test types and rounding done");
  endtask
  task automatic t_route();
    for (int r = 0; r < 8; r++) begin
      start(mk(TYPE_ASYM, {2'b11, r[2:1], r[0], 1'b0, 5'h15}, 3'h0, 10'h0, 3'h7, 1'b0));
      chk("agc_loop_gain_sel_o", 0, agc_loop_gain_sel_o);
      pulse(0, 24'h123450 + r, 24'h0);
      chk("recirc_valid_o", r < 2, recirc_valid_o);
      if (r < 2) chk("recirc_i_o", 24'h123450 + r, recirc_i_o);
      if (r < 2) chk("recirc_step_o", 5'h15, recirc_step_o);
      chk("agc_fwd_valid_o", r[2:1] == 1, agc_fwd_valid_o);
      chk("agc_loop_update_o", r[2:1] == 1, agc_loop_update_o);
      chk("direct_valid_o", r[2:1] == 2, direct_valid_o);
      chk("next_chan_valid_o", r[2:1] == 2, next_chan_valid_o);
      chk("data_ready_o", (r == 3 || r == 5), data_ready_o);
      chk("serial_start_o", (r == 3 || r == 5), serial_start_o);
      if (r inside {[2:5]}) chk("hold_i_o", 24'h123450 + r, hold_i_o);
      pulse(4, '0, '0);
    end
    $display("test routing done");
  endtask
  task automatic t_fb();
    logic [31:0] rd;
    logic        er;
    start(mk(TYPE_ASYM, 11'h02a, 3'h0, 10'h0, 3'h7, 1'b0));
    pulse(1, 24'h00abcd, 24'h000777);
    chk("recirc_valid_o", 1, recirc_valid_o);
    chk("recirc_i_o", 24'h00abcd, recirc_i_o);
    chk("recirc_q_o", 24'h000777, recirc_q_o);
    chk("recirc_step_o", 5'h0a, recirc_step_o);
    u_cpu.xfer(1'b0, OFS_STATUS, '0, rd, er);
    chk("status", {KIND_ASYM, 8'h01}, rd[11:0]);
    u_cpu.xfer(1'b0, 12'h010, '0, rd, er);
    chk("pslverr_o", 1, er);
    chk("prdata_o", 0, rd);
    pulse(4, '0, '0);
    $display("test feedback and registers done");
  endtask
  task automatic t_addr_rot();
    logic [DATA_W-1:0] ei [4];
    logic [DATA_W-1:0] eq [4];
    ei = '{24'h5, -24'h3, -24'h5, 24'h3};
    eq = '{24'h3, 24'h5, -24'h3, -24'h5};
    start(mk(TYPE_SYM_EE, 11'h0, 3'h0, 10'h040, 3'h0, 1'b1));
    chk("data_addr_o", 10'h040, data_addr_o);
    pulse(3, '0, '0);
    chk("data_addr_o", 10'h047, data_addr_o);
    pulse(3, '0, '0);
    chk("data_addr_o", 10'h046, data_addr_o);
    for (int p = 0; p < 4; p++) begin
      pulse(2, 24'h5, 24'h3);
      chk("rot_valid_o", 1, rot_valid_o);
      chk("rot_i_o", ei[p], rot_i_o);
      chk("rot_q_o", eq[p], rot_q_o);
    end
    pulse(4, '0, '0);
    chk("data_addr_o", 10'h041, data_addr_o);
    $display("test address and rotator done");
  endtask

  initial begin
    reset_i = 1'b1;
    {result_valid_i, polar_valid_i, data_in_valid_i, tap_i, run_done_i} = 5'h0;
    {result_i_i, polar_mag_i, data_in_i_i, result_q_i, polar_dphi_i, data_in_q_i} = '0;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("fir_kind_o", KIND_NOP, fir_kind_o);
    chk("data_addr_o", 0, data_addr_o);
    $display("test reset done");
    t_types();
    t_route();
    t_fb();
    t_addr_rot();
    stop_test();
  end
endmodule // fir_instruction_field_decoder_tb
`default_nettype wire
